// [rcw_dummy_unused_check.sv]
`timescale 1ns/1ps

// [rcw_pkg.sv]
package rcw_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [29:0] RCW_IDX_CFG    = 30'h0000000A;
	localparam logic [29:0] RCW_IDX_STORED = 30'h0000000F;
	localparam logic [29:0] RCW_IDX_MAXLIM = 30'h00000010;
	localparam logic [29:0] RCW_IDX_STATUS = 30'h00000027;
	localparam logic [29:0] RCW_IDX_VOLREF = 30'h00000031;

	////////////////////////////////////////////////////////////////////////
	// Configuration word bit positions
	localparam int RCW_B_PERIODIC = 1;
	localparam int RCW_B_OFFSET   = 2;
	localparam int RCW_B_JUMPER   = 4;
	localparam int RCW_B_APO_INV  = 5;
	localparam int RCW_B_FORCE3   = 6;
	localparam int RCW_B_RAMREF   = 7;
	localparam int RCW_B_KNOB0    = 8;
	localparam int RCW_B_EXTIN    = 12;
	localparam int RCW_B_DAC      = 13;
	localparam int RCW_B_60HZ     = 14;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RCW_CFG_RST    = 16'h1F34;
	localparam logic [15:0] RCW_STORED_RST = 16'h4000;
	localparam logic [15:0] RCW_MAXLIM_RST = 16'h48F5;

	typedef enum logic [1:0] {
		RCW_SRC_ANA,
		RCW_SRC_ANA_SAT,
		RCW_SRC_STORED,
		RCW_SRC_VOLATILE
	} rcw_src_t;

	typedef struct packed {
		logic        three_phase_sensed;
		logic        jumper_60hz;
		logic        analog_connected;
		logic        analog_at_limit;
		logic [15:0] analog_level;
	} rcw_pins_t;

	typedef struct packed {
		logic periodic_ref_en;
		logic offset_comp_en;
		logic jumper_read_en;
		logic aux_protection_output_inv;
		logic three_phase;
		logic output_level_knob_en;
		logic loop_gain_knob_en;
		logic underfrequency_knob_en;
		logic overexcitation_knob_en;
		logic ext_input_en;
		logic ext_dac_en;
		logic sel_60hz;
		logic saturation_en;
	} rcw_ctrl_t;

	typedef struct packed {
		rcw_pins_t   pin_meta;
		rcw_pins_t   pin_sync;
		logic [15:0] cfg;
		logic [15:0] stored_ref;
		logic [15:0] max_lim;
		logic [15:0] vol_ref;
		logic [15:0] setpoint;
		logic        act;
		logic        wr;
		logic [29:0] idx;
		logic [31:0] rdata;
	} rcw_state_t;

endpackage

// [rcw_top.sv]
`timescale 1ns/1ps

// Functional notes
// - Each used config bit turns its function on at one, off at zero, except bits 7 and 14, which pick the reference source and the line frequency.
// - The config word comes out of reset holding 7988.
// - Bit 2 enables offset compensation, only under single phase.
// - Bit 14 picks 60 Hz when jumper reading is off, else the jumper pin picks it.
// - Bit 12 enables the analog input, bits 8 to 11 the four knobs.
// - Analog input with bit 7 set clamps the setpoint at the limit.
// - Saturated analog mode with a lost link forces the max limit.
// - Analog off and bit 7 clear takes the stored reference.
// - In stored mode the volatile ref tracks stored, writes ignored.
// - Analog off and bit 7 set takes the volatile reference.
// - Bit 6 clear auto-detects phases, bit 6 set forces three phase.
// - Status bit 6 reads one whenever three phase is sensed.
module rcw_top
	import rcw_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire rcw_pkg::rcw_pins_t pins,
	output rcw_pkg::rcw_ctrl_t     ctrl,
	output rcw_pkg::rcw_src_t      vref_source,
	output logic [15:0]            vref_setpoint,
	output logic [15:0]            active_config
);
	import rcw_pkg::*;

	rcw_state_t s_q;
	rcw_state_t s_d;
	rcw_ctrl_t  c;
	rcw_src_t   src;
	logic [15:0] status;
	logic [15:0] sp;
	logic [15:0] lvl;

	////////////////////////////////////////////////////////////////////////
	// Function enables from the stored word
	always_comb begin
		c = '0;
		c.periodic_ref_en = s_q.cfg[RCW_B_PERIODIC];
		c.three_phase = s_q.cfg[RCW_B_FORCE3] |
			s_q.pin_sync.three_phase_sensed;
		c.offset_comp_en = s_q.cfg[RCW_B_OFFSET] & ~c.three_phase;
		c.jumper_read_en = s_q.cfg[RCW_B_JUMPER];
		c.aux_protection_output_inv = s_q.cfg[RCW_B_APO_INV];
		c.output_level_knob_en = s_q.cfg[RCW_B_KNOB0];
		c.loop_gain_knob_en = s_q.cfg[RCW_B_KNOB0 + 1];
		c.underfrequency_knob_en = s_q.cfg[RCW_B_KNOB0 + 2];
		c.overexcitation_knob_en = s_q.cfg[RCW_B_KNOB0 + 3];
		c.ext_input_en = s_q.cfg[RCW_B_EXTIN];
		c.ext_dac_en = s_q.cfg[RCW_B_DAC];
		c.sel_60hz = c.jumper_read_en ? s_q.pin_sync.jumper_60hz :
			s_q.cfg[RCW_B_60HZ];
		c.saturation_en = s_q.cfg[RCW_B_EXTIN] & s_q.cfg[RCW_B_RAMREF];
	end

	////////////////////////////////////////////////////////////////////////
	// Reference source decode
	always_comb begin
		case ({s_q.cfg[RCW_B_EXTIN], s_q.cfg[RCW_B_RAMREF]})
			2'b10: src = RCW_SRC_ANA;
			2'b11: src = RCW_SRC_ANA_SAT;
			2'b00: src = RCW_SRC_STORED;
			2'b01: src = RCW_SRC_VOLATILE;
			default: src = RCW_SRC_STORED;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Active configuration view
	always_comb begin
		status = s_q.cfg;
		status[RCW_B_OFFSET] = c.offset_comp_en;
		status[RCW_B_FORCE3] = c.three_phase;
		status[RCW_B_60HZ] = c.sel_60hz;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.pin_meta = pins;
		s_d.pin_sync = s_q.pin_meta;
		// Data phase of a write
		if (s_q.act && s_q.wr) begin
			case (s_q.idx)
				RCW_IDX_CFG:
					s_d.cfg = hwdata[15:0];
				RCW_IDX_STORED:
					s_d.stored_ref = hwdata[15:0];
				RCW_IDX_MAXLIM:
					s_d.max_lim = hwdata[15:0];
				RCW_IDX_VOLREF: begin
					if (src != RCW_SRC_STORED) begin
						s_d.vol_ref = hwdata[15:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Volatile ref follows the stored one in stored mode
		if (src == RCW_SRC_STORED) begin
			s_d.vol_ref = s_d.stored_ref;
		end
		// Address phase
		s_d.act = hsel && htrans[1] && hready;
		if (hsel && htrans[1] && hready) begin
			s_d.wr = hwrite;
			s_d.idx = haddr[31:2];
		end
		// Read data sees a write landing this cycle, except status, which uses the current config
		s_d.rdata = '0;
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[31:2])
				RCW_IDX_CFG:    s_d.rdata = {16'h0000, s_d.cfg};
				RCW_IDX_STORED: s_d.rdata = {16'h0000, s_d.stored_ref};
				RCW_IDX_MAXLIM: s_d.rdata = {16'h0000, s_d.max_lim};
				RCW_IDX_STATUS: s_d.rdata = {16'h0000, status};
				RCW_IDX_VOLREF: s_d.rdata = {16'h0000, s_d.vol_ref};
				default:        s_d.rdata = '0;
			endcase
		end
		// Setpoint from the next-state reference and limit, with source and pin levels from the current state, kept in this one process
		lvl = s_q.pin_sync.analog_level;
		sp = s_d.stored_ref;
		case (src)
			RCW_SRC_ANA: begin
				sp = lvl;
			end
			RCW_SRC_ANA_SAT: begin
				if (!s_q.pin_sync.analog_connected) begin
					sp = s_d.max_lim;
				end else if (s_q.pin_sync.analog_at_limit ||
					lvl > s_d.max_lim) begin
					sp = s_d.max_lim;
				end else begin
					sp = lvl;
				end
			end
			RCW_SRC_STORED: begin
				sp = s_d.stored_ref;
			end
			RCW_SRC_VOLATILE: begin
				sp = s_d.vol_ref;
			end
			default: begin
				sp = s_d.stored_ref;
			end
		endcase
		s_d.setpoint = sp;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.cfg <= RCW_CFG_RST;
			s_q.stored_ref <= RCW_STORED_RST;
			s_q.max_lim <= RCW_MAXLIM_RST;
			s_q.vol_ref <= RCW_STORED_RST;
			s_q.setpoint <= RCW_STORED_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign ctrl = c;
	assign vref_source = src;
	assign vref_setpoint = s_q.setpoint;
	assign active_config = status;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence cfg_wr_addr;
		hsel && htrans[1] && hready && hwrite &&
			haddr[31:2] == RCW_IDX_CFG;
	endsequence

	sequence sat_lost;
		src == RCW_SRC_ANA_SAT && !s_q.pin_sync.analog_connected;
	endsequence

	a_cfg_write_lands: assert property (
		cfg_wr_addr ##1 1'b1 |=> s_q.cfg == $past(hwdata[15:0]))
		else $error("config write not stored");

	a_offset_single: assert property (
		ctrl.offset_comp_en == (s_q.cfg[RCW_B_OFFSET] &&
			!s_q.cfg[RCW_B_FORCE3] && !s_q.pin_sync.three_phase_sensed))
		else $error("offset compensation wrong");

	a_freq_select: assert property (
		!s_q.cfg[RCW_B_JUMPER] |-> ctrl.sel_60hz == s_q.cfg[RCW_B_60HZ])
		else $error("60 Hz select wrong");

	a_knob_enables: assert property (
		{ctrl.overexcitation_knob_en, ctrl.underfrequency_knob_en,
			ctrl.loop_gain_knob_en, ctrl.output_level_knob_en,
			ctrl.ext_input_en} ==
			{s_q.cfg[RCW_B_KNOB0+3:RCW_B_KNOB0], s_q.cfg[RCW_B_EXTIN]})
		else $error("knob enable wrong");

	a_sat_clamp: assert property (
		src == RCW_SRC_ANA_SAT && s_q.pin_sync.analog_connected &&
			s_q.pin_sync.analog_at_limit && !(s_q.act && s_q.wr)
			|=> vref_setpoint == $past(s_q.max_lim))
		else $error("saturation clamp missing");

	a_loss_to_max: assert property (
		sat_lost ##1 sat_lost |-> vref_setpoint == $past(s_d.max_lim))
		else $error("lost link not at max");

	a_stored_used: assert property (
		src == RCW_SRC_STORED |=> vref_setpoint == s_q.stored_ref)
		else $error("stored reference not used");

	a_vol_aligned: assert property (
		src == RCW_SRC_STORED |=> s_q.vol_ref == s_q.stored_ref)
		else $error("volatile ref not aligned");

	a_vol_used: assert property (
		src == RCW_SRC_VOLATILE |=> vref_setpoint == s_q.vol_ref)
		else $error("volatile reference not used");

	a_force_three: assert property (
		s_q.cfg[RCW_B_FORCE3] |-> ctrl.three_phase)
		else $error("three phase not forced");

	a_status_b6: assert property (
		s_q.pin_sync.three_phase_sensed |->
			active_config[RCW_B_FORCE3])
		else $error("status bit 6 not set");

	a_src_decode: assert property (
		vref_source == rcw_src_t'({~s_q.cfg[RCW_B_EXTIN],
			s_q.cfg[RCW_B_RAMREF]}))
		else $error("source decode wrong");

	a_read_word: assert property (
		hsel && htrans[1] && hready && !hwrite &&
			haddr[31:2] == RCW_IDX_CFG |=>
			hrdata == {16'h0000, s_q.cfg})
		else $error("config read data wrong");

endmodule

// [test_regulator_config_word.sv]
`timescale 1ns/1ps

module test_regulator_config_word;
	import rcw_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	rcw_pins_t   pins;
	rcw_ctrl_t   ctrl;
	rcw_src_t    vref_source;
	logic [15:0] vref_setpoint;
	logic [15:0] active_config;
	logic        rd_phase;
	logic [2:0]  port_chk;
	logic [31:0] exp_q[$];
	logic [31:0] obs;
	logic [31:0] e;
	logic [31:0] seed;
	logic [15:0] cfg;
	logic [15:0] val;
	logic        tp;
	logic        jm;
	int          mismatches;
	int          tests_run;

	assign hready = hreadyout;

	rcw_top rcw_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .pins(pins), .ctrl(ctrl),
		.vref_source(vref_source), .vref_setpoint(vref_setpoint),
		.active_config(active_config)
	);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	// Monitor: oldest note against what the outputs show
	always @(posedge hclk) begin
		if ((rd_phase && hready) || port_chk != 3'd0) begin
			case (port_chk)
				3'd1: obs = {30'h0, vref_source};
				3'd2: obs = {16'h0, vref_setpoint};
				3'd3: obs = {16'h0, active_config};
				3'd4: obs = {19'h0, ctrl};
				3'd5: obs = {30'h0, hresp, hreadyout};
				default: obs = hrdata;
			endcase
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			tests_run++;
			if (obs !== e) begin
				mismatches++;
				$display("Error at %0t: got %h expected %h", $time, obs, e);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus and check tasks
	task automatic bus_addr(input logic [29:0] idx, input logic wr);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
	endtask

	task automatic wr_reg(input logic [29:0] idx, input logic [15:0] d);
		bus_addr(idx, 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {16'h0, d};
		@(posedge hclk);
		while (!hready) @(posedge hclk);
	endtask

	task automatic rd_reg(input logic [29:0] idx, input logic [31:0] x);
		bus_addr(idx, 1'b0);
		htrans   <= 2'b00;
		hsel     <= 1'b0;
		rd_phase <= 1'b1;
		exp_q.push_back(x);
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		rd_phase <= 1'b0;
	endtask

	task automatic chk(input logic [2:0] k, input logic [31:0] x);
		@(posedge hclk);
		port_chk <= k;
		exp_q.push_back(x);
		@(posedge hclk);
		port_chk <= 3'd0;
	endtask

	function automatic rcw_src_t src_of(input logic [15:0] c);
		if (c[12]) return c[7] ? RCW_SRC_ANA_SAT : RCW_SRC_ANA;
		return c[7] ? RCW_SRC_VOLATILE : RCW_SRC_STORED;
	endfunction

	task automatic chk_cfg(input logic [15:0] c, input logic t,
		input logic j);
		rcw_ctrl_t   r;
		logic [15:0] s;
		r = '0;
		r.periodic_ref_en = c[1];
		r.three_phase = c[6] | t;
		r.offset_comp_en = c[2] & ~r.three_phase;
		r.jumper_read_en = c[4];
		r.aux_protection_output_inv = c[5];
		r.output_level_knob_en = c[8];
		r.loop_gain_knob_en = c[9];
		r.underfrequency_knob_en = c[10];
		r.overexcitation_knob_en = c[11];
		r.ext_input_en = c[12];
		r.ext_dac_en = c[13];
		r.sel_60hz = c[4] ? j : c[14];
		r.saturation_en = c[12] & c[7];
		s = c;
		s[2] = r.offset_comp_en;
		s[6] = r.three_phase;
		s[14] = r.sel_60hz;
		chk(3'd4, {19'h0, r});
		chk(3'd3, {16'h0, s});
		chk(3'd1, {30'h0, src_of(c)});
	endtask

	task automatic results();
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'hC8B5CAE2;
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
		pins = '0;
		rd_phase = 1'b0;
		port_chk = 3'd0;
		mismatches = 0;
		tests_run = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk(3'd5, 32'h00000001);
		rd_reg(RCW_IDX_CFG, 32'h00001F34);
		chk_cfg(16'h1F34, 1'b0, 1'b0);
		rd_reg(RCW_IDX_MAXLIM, {16'h0, RCW_MAXLIM_RST});
		rd_reg(30'h00000020, 32'h0);
		// Random words through every source mode and both sensed-phase states
		for (int i = 0; i < 8; i++) begin
			cfg = 16'($random(seed));
			cfg[12] = i[1];
			cfg[7] = i[0];
			// Force, sensed-only and offset masking all reached
			cfg[6] = i[0] ^ i[2];
			cfg[4] = ~i[0];
			cfg[2] = ~i[1];
			tp = i[2];
			jm = 1'($random(seed));
			pins.three_phase_sensed <= tp;
			pins.jumper_60hz <= jm;
			wr_reg(RCW_IDX_CFG, cfg);
			rd_reg(RCW_IDX_CFG, {16'h0, cfg});
			chk_cfg(cfg, tp, jm);
		end
		// Stored mode: volatile copy follows stored, writes ignored
		wr_reg(RCW_IDX_CFG, 16'h0000);
		val = 16'($random(seed));
		wr_reg(RCW_IDX_STORED, val);
		wr_reg(RCW_IDX_VOLREF, ~val);
		rd_reg(RCW_IDX_VOLREF, {16'h0, val});
		chk(3'd2, {16'h0, val});
		// Volatile mode takes the written location
		wr_reg(RCW_IDX_CFG, 16'h0080);
		wr_reg(RCW_IDX_VOLREF, ~val);
		rd_reg(RCW_IDX_VOLREF, {16'h0, ~val});
		chk(3'd2, {16'h0, ~val});
		// Analog without saturation follows the level
		wr_reg(RCW_IDX_CFG, 16'h1000);
		val = 16'($random(seed));
		pins <= '{1'b0, 1'b0, 1'b0, 1'b1, val};
		repeat (4) @(posedge hclk);
		chk(3'd2, {16'h0, val});
		// Saturated analog: lost link, limit flag, level over limit
		wr_reg(RCW_IDX_CFG, 16'h1080);
		for (int k = 0; k < 4; k++) begin
			val = (k == 3) ? 16'hFFFF : 16'h1234;
			pins <= '{1'b0, 1'b0, k != 0, k == 2, val};
			repeat (4) @(posedge hclk);
			chk(3'd2, {16'h0, (k == 1) ? val : RCW_MAXLIM_RST});
		end
		repeat (2) @(posedge hclk);
		results();
	end

endmodule
